// ==== breaker_autoreclose_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: up to four shots, each with own dead time and settings bank.
// RULE2: any overcurrent trip or external initiate input starts a sequence.
// RULE3: enabled: setting, contact, no block/cancel, no lockout, hold idle.
// RULE4: status shows exactly one of enabled, disabled, in progress, lockout.
// RULE5: dead timer starts only once breaker reported open.
// RULE6: dead time elapsed bumps shot counter and pulses close relay.
// RULE7: settings bank switches to the new shot number with the close.
// RULE8: trip with shot counter at limit goes to lockout.
// RULE9: breaker failure forces lockout from any state.
// RULE10: in lockout reclose disabled and initial settings selected.
// RULE11: panel, input, comms reset or supervised manual close clear lockout.
// RULE12: manual close clears lockout only after hold time, no overcurrent.
// RULE13: reset timer starts at first initiation, auto reset when exceeded.
// RULE14: auto reset zeroes shot counter and restores initial settings.
// RULE15: repeated trip-close-reset cycle restores settings, keeps shot count.
// RULE16: high fault current lowers the permitted shot count.
// RULE17: hold timer expiry without overcurrent clears lockout, zeroes count.
// RULE18: shot timeout before close conditions met abandons the initiation.
// RULE19: all timers count a common tick from the system clock.
// RULE20: reset gives idle, no lockout, zero shots, initial settings.
module breaker_autoreclose_sequencer #(
  parameter int unsigned TICK_DIV = ar_pkg::TICK_CYCLES,
  parameter int unsigned TW       = ar_pkg::TIME_W,
  parameter int unsigned CW       = ar_pkg::CUR_W
) (
  // clock and reset
  input  wire logic          mclk_in,
  input  wire logic          rst_in,
  // configuration, times in ticks
  input  wire logic          ar_enable_in,
  input  wire logic          contact_fitted_in,
  input  wire logic [2:0]    shot_limit_in,
  input  wire logic [4*TW-1:0] dead_time_in,
  input  wire logic [TW-1:0] sequence_reset_time_in,
  input  wire logic [TW-1:0] manual_close_hold_time_in,
  input  wire logic [TW-1:0] shot_timeout_in,
  input  wire logic          cur_sup_enable_in,
  input  wire logic [3*CW-1:0] cur_sup_level_in,
  input  wire logic          cur_lockout_enable_in,
  input  wire logic [CW-1:0] cur_lockout_level_in,
  input  wire logic [CW-1:0] fault_current_in,
  // protection and logic inputs (pins)
  input  wire logic          oc_trip_in,
  input  wire logic          oc_active_in,
  input  wire logic          ext_initiate_in,
  input  wire logic          block_in,
  input  wire logic          cancel_in,
  input  wire logic          breaker_fail_in,
  input  wire logic          close_block_in,
  input  wire logic          breaker_closed_contact_in,
  input  wire logic          breaker_open_contact_in,
  // reset sources and manual close
  input  wire logic          panel_reset_in,
  input  wire logic          reset_input_in,
  input  wire logic          comms_reset_in,
  input  wire logic          manual_close_in,
  input  wire logic          sync_reset_in,
  // outputs
  output logic               close_relay_out,
  output logic [2:0]         settings_bank_out,
  output logic [2:0]         shot_count_out,
  output logic [1:0]         status_out
);
  if (TW < 2 || CW < 1) begin : g_bad_width
    $error("breaker_autoreclose_sequencer: bad width");
  end

  // pin inputs: three flops, then a fourth that takes stage 3 when stages 2 and 3 agree
  localparam int NP = 10;
  wire [NP-1:0] pin_raw = {oc_trip_in, oc_active_in, ext_initiate_in,
                           block_in, cancel_in, breaker_fail_in,
                           close_block_in, breaker_closed_contact_in,
                           breaker_open_contact_in, manual_close_in};
  logic [NP-1:0] pin_s1, pin_s2, pin_s3, pin_q;
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
          pin_q[gi]  <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) pin_q[gi] <= pin_s3[gi];
        end
      end
    end
  endgenerate
  wire oc_trip  = pin_q[9];
  wire oc_act   = pin_q[8];
  wire ext_init = pin_q[7];
  wire blk      = pin_q[6];
  wire cnl      = pin_q[5];
  wire bkr_fail = pin_q[4];
  wire cls_blk  = pin_q[3];
  wire bkr_cl   = pin_q[2];
  wire bkr_op   = pin_q[1];
  wire man_cl   = pin_q[0];

  // RULE19 common tick
  logic tick;
  ar_tick #(.DIV(TICK_DIV)) u_tick (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .tick_out(tick)
  );

  ar_pkg::ar_state_t state, next_state;
  logic [2:0]    shots, bank, eff_limit;
  logic [TW-1:0] phase_t, seq_t, hold_t;
  logic          seq_run, hold_run, trip_q, man_q, pumping, reset_seen;

  // edges, trip also from external initiate
  // RULE2 trip or external initiate
  wire initiate  = (oc_trip | ext_init) & ~trip_q;
  wire man_edge  = man_cl & ~man_q;
  // breaker open: open contact or absence of closed contact
  wire is_open   = bkr_op | ~bkr_cl;
  wire hold_exp  = hold_run & tick & (hold_t >= manual_close_hold_time_in);
  wire seq_exp   = seq_run & tick & (seq_t >= sequence_reset_time_in);
  wire [TW-1:0] dead_sel = dead_time_in[(shots[1:0])*TW +: TW];
  wire dead_done = tick & (phase_t >= dead_sel);
  wire shot_to   = tick & (phase_t >= shot_timeout_in);
  // RULE3 six enable conditions
  wire enabled   = ar_enable_in & contact_fitted_in & ~blk & ~cnl &
                   (state != ar_pkg::ST_LOCKOUT) & ~hold_run;
  wire ext_reset = panel_reset_in | reset_input_in | comms_reset_in;

  // RULE16 current supervision lowers the limit
  wire [CW-1:0] lvl3 = cur_sup_level_in[0*CW +: CW];
  wire [CW-1:0] lvl2 = cur_sup_level_in[1*CW +: CW];
  wire [CW-1:0] lvl1 = cur_sup_level_in[2*CW +: CW];
  wire [2:0] base_lim = (shot_limit_in > 3'h4) ? 3'h4 : shot_limit_in;
  wire [2:0] cur_lim  = !cur_sup_enable_in ? 3'h4 :
                        (fault_current_in > lvl1) ? 3'h1 :
                        (fault_current_in > lvl2) ? 3'h2 :
                        (fault_current_in > lvl3) ? 3'h3 : 3'h4;
  wire [2:0] new_lim  = (cur_lim < base_lim) ? cur_lim : base_lim;
  wire cur_lock = cur_lockout_enable_in &
                  (fault_current_in > cur_lockout_level_in);
  // RULE8 limit reached on trip
  wire at_limit = (shots >= eff_limit) | (shots >= new_lim) | cur_lock;

  always_comb begin
    next_state = state;
    case (state)
      ar_pkg::ST_IDLE: begin
        if (initiate && enabled) next_state = at_limit ?
          ar_pkg::ST_LOCKOUT : ar_pkg::ST_WAIT_OPEN;
      end
      ar_pkg::ST_WAIT_OPEN: begin
        // RULE5 dead timer waits for open breaker
        if (is_open) next_state = ar_pkg::ST_DEAD;
        else if (shot_to) next_state = ar_pkg::ST_IDLE;
      end
      ar_pkg::ST_DEAD: begin
        // RULE18 shot timeout abandons initiation
        if (shot_to && (cls_blk || !is_open)) next_state = ar_pkg::ST_IDLE;
        else if (dead_done && !cls_blk) next_state = ar_pkg::ST_CLOSING;
      end
      ar_pkg::ST_CLOSING: next_state = ar_pkg::ST_RECLAIM;
      ar_pkg::ST_RECLAIM: begin
        if (initiate) next_state = at_limit ?
          ar_pkg::ST_LOCKOUT : ar_pkg::ST_WAIT_OPEN;
        else if (seq_exp) next_state = ar_pkg::ST_IDLE;
      end
      ar_pkg::ST_LOCKOUT: begin
        // RULE11 four ways out of lockout
        // RULE12 manual close supervised by hold timer and overcurrent
        if (ext_reset || (hold_exp && !oc_act)) next_state = ar_pkg::ST_IDLE;
      end
      default: next_state = ar_pkg::ST_IDLE;
    endcase
    // RULE9 breaker failure wins over everything except sync_reset_in
    if (bkr_fail) next_state = ar_pkg::ST_LOCKOUT;
    if (cnl && state != ar_pkg::ST_LOCKOUT && !bkr_fail)
      next_state = ar_pkg::ST_IDLE;
  end

  wire enter_close = (state == ar_pkg::ST_DEAD) &&
                     (next_state == ar_pkg::ST_CLOSING);
  wire leaving_seq = seq_exp && (state == ar_pkg::ST_RECLAIM) &&
                     (next_state == ar_pkg::ST_IDLE);
  wire new_phase   = (next_state != state);
  // an abandoned or cancelled sequence must not leave the reset timer running
  wire to_idle     = (next_state == ar_pkg::ST_IDLE) &&
                     (state != ar_pkg::ST_IDLE);

  // RULE20 synchronous reset to idle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) state <= ar_pkg::ST_IDLE;
    else if (sync_reset_in) state <= ar_pkg::ST_IDLE;
    else state <= next_state;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      trip_q <= 1'b0;
      man_q  <= 1'b0;
    end else begin
      trip_q <= oc_trip | ext_init;
      man_q  <= man_cl;
    end
  end

  // phase timer serves both dead time and shot timeout
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) phase_t <= '0;
    else if (sync_reset_in || new_phase) phase_t <= '0;
    else if (tick && phase_t != '1) phase_t <= phase_t + TW'(1);
  end

  // RULE13 reset timer from first initiation
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      seq_run <= 1'b0;
      seq_t   <= '0;
    end else if (sync_reset_in || next_state == ar_pkg::ST_LOCKOUT ||
                 to_idle) begin
      seq_run <= 1'b0;
      seq_t   <= '0;
    end else if (initiate && !seq_run &&
                 next_state == ar_pkg::ST_WAIT_OPEN) begin
      seq_run <= 1'b1;
      seq_t   <= '0;
    end else if (seq_run && tick && seq_t != '1) begin
      seq_t <= seq_t + TW'(1);
    end
  end

  // hold timer after manual close blocks the scheme meanwhile
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_run <= 1'b0;
      hold_t   <= '0;
    end else if (sync_reset_in) begin
      hold_run <= 1'b0;
      hold_t   <= '0;
    end else if (man_edge) begin
      hold_run <= 1'b1;
      hold_t   <= '0;
    end else if (hold_exp || (hold_run && oc_act)) begin
      hold_run <= 1'b0;
      hold_t   <= '0;
    end else if (hold_run && tick) begin
      hold_t <= hold_t + TW'(1);
    end
  end

  // anti-pumping: any trip after an auto reset, until lockout or reset, marks a pumping cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      reset_seen <= 1'b0;
      pumping    <= 1'b0;
    end else if (sync_reset_in || next_state == ar_pkg::ST_LOCKOUT ||
                 ext_reset || (hold_exp && !oc_act)) begin
      reset_seen <= 1'b0;
      pumping    <= 1'b0;
    end else begin
      if (leaving_seq && shots != ar_pkg::SHOT_RESET) reset_seen <= 1'b1;
      // RULE15 repeat detected, keep count
      if (initiate && reset_seen && state == ar_pkg::ST_IDLE) pumping <= 1'b1;
    end
  end

  // shot counter, limit and settings bank
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      shots     <= ar_pkg::SHOT_RESET;
      bank      <= ar_pkg::SHOT_RESET;
      eff_limit <= 3'h4;
    end else if (sync_reset_in) begin
      shots     <= ar_pkg::SHOT_RESET;
      bank      <= ar_pkg::SHOT_RESET;
      eff_limit <= 3'h4;
    end else if (next_state == ar_pkg::ST_LOCKOUT) begin
      // RULE10 lockout restores initial settings
      bank <= ar_pkg::SHOT_RESET;
      if (ext_reset) shots <= ar_pkg::SHOT_RESET;
    end else if (state == ar_pkg::ST_LOCKOUT &&
                 next_state == ar_pkg::ST_IDLE) begin
      // RULE17 lockout cleared, count to zero
      shots     <= ar_pkg::SHOT_RESET;
      eff_limit <= 3'h4;
    end else if (enter_close) begin
      // RULE6 count the shot
      // RULE7 settings follow the shot number
      // RULE1 four shots at most
      shots <= (shots < 3'h4) ? shots + 3'h1 : shots;
      bank  <= (shots < 3'h4) ? shots + 3'h1 : shots;
    end else if (leaving_seq) begin
      // RULE14 auto reset clears settings, and clears count unless reset_seen
      bank <= ar_pkg::SHOT_RESET;
      if (!reset_seen || shots == ar_pkg::SHOT_RESET)
        shots <= ar_pkg::SHOT_RESET;
      if (!reset_seen) eff_limit <= 3'h4;
    end else begin
      if (initiate && next_state == ar_pkg::ST_WAIT_OPEN)
        eff_limit <= (new_lim < eff_limit) ? new_lim : eff_limit;
      if (pumping) bank <= ar_pkg::SHOT_RESET;
    end
  end

  // RULE4 exclusive status
  wire [1:0] next_status =
    (state == ar_pkg::ST_LOCKOUT) ? ar_pkg::STAT_LOCKOUT :
    (state == ar_pkg::ST_WAIT_OPEN || state == ar_pkg::ST_DEAD) ?
      ar_pkg::STAT_PROGRESS :
    enabled ? ar_pkg::STAT_ENABLED : ar_pkg::STAT_DISABLED;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      close_relay_out   <= 1'b0;
      settings_bank_out <= ar_pkg::SHOT_RESET;
      shot_count_out    <= ar_pkg::SHOT_RESET;
      status_out        <= ar_pkg::STAT_DISABLED;
    end else begin
      close_relay_out   <= (state == ar_pkg::ST_CLOSING);
      settings_bank_out <= bank;
      shot_count_out    <= shots;
      status_out        <= next_status;
    end
  end

  default clocking cb_main @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  // RULE9 failure reaches lockout
  bkr_fail_a: assert property ( // RULE9
    (bkr_fail && !sync_reset_in) |=> state == ar_pkg::ST_LOCKOUT)
    else $error("breaker failure did not lock out");
  // RULE10 initial settings in lockout
  lock_bank_a: assert property ( // RULE10
    state == ar_pkg::ST_LOCKOUT |-> ##1 bank == 3'h0)
    else $error("settings not initial in lockout");
  // RULE6 close follows closing state
  close_pulse_a: assert property ( // RULE6
    $rose(close_relay_out) |-> $past(state) == ar_pkg::ST_CLOSING)
    else $error("close relay without closing state");
  // RULE7 bank tracks shot on close
  bank_shot_a: assert property ( // RULE7
    state == ar_pkg::ST_CLOSING |->
      bank == shots && shots == $past(shots) + 3'h1)
    else $error("settings bank differs from shot");
  // RULE1 shot count bounded
  shot_max_a: assert property ( // RULE1
    shots <= 3'h4)
    else $error("shot count above four");
  // RULE5 dead timing needs open breaker
  dead_open_a: assert property ( // RULE5
    (state == ar_pkg::ST_DEAD && $past(state) != ar_pkg::ST_DEAD) |->
      $past(is_open))
    else $error("dead timer without open");
  // RULE3 enabled status needs setting
  en_stat_a: assert property ( // RULE3
    (status_out == ar_pkg::STAT_ENABLED) |-> $past(ar_enable_in))
    else $error("enabled with setting off");
  // RULE20 sync reset to idle
  sync_rst_a: assert property ( // RULE20
    sync_reset_in |=> state == ar_pkg::ST_IDLE && shots == 3'h0)
    else $error("sync reset not idle");
endmodule : breaker_autoreclose_sequencer
`default_nettype wire

// ==== ar_pkg.sv ====
package ar_pkg;
  // timebase: 1 ms tick at 25 MHz
  localparam int unsigned CLK_HZ       = 25000000;
  localparam int unsigned TICK_US      = 1000;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000000 * TICK_US;
  localparam int unsigned TIME_W       = 16;
  localparam int unsigned MAX_SHOTS    = 4;
  localparam int unsigned SHOT_W       = 3;
  localparam int unsigned CUR_W        = 12;
  localparam logic [2:0]  SHOT_RESET   = 3'h0;
  localparam logic [1:0]  STAT_ENABLED  = 2'h0;
  localparam logic [1:0]  STAT_DISABLED = 2'h1;
  localparam logic [1:0]  STAT_PROGRESS = 2'h2;
  localparam logic [1:0]  STAT_LOCKOUT  = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_OPEN, ST_DEAD, ST_CLOSING, ST_RECLAIM, ST_LOCKOUT
  } ar_state_t;
endpackage : ar_pkg

// ==== ar_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
module ar_tick #(
  parameter int unsigned DIV = ar_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // timebase pulse
  output logic      tick_out
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  if (DIV < 1) begin : g_bad_div
    $error("ar_tick: DIV must be at least 1");
  end
  logic [CW-1:0] count;
  wire last = (count == CW'(DIV - 1));
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else begin
      count    <= last ? '0 : count + CW'(1);
      tick_out <= last;
    end
  end
endmodule : ar_tick
`default_nettype wire

// ==== breaker_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module breaker_model (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // commands
  input  wire logic       trip_in,
  input  wire logic       close_in,
  input  wire logic       stuck_in,
  input  wire logic [7:0] delay_in,
  // status contacts
  output logic            closed_out,
  output logic            open_out
);
  logic       closed;
  logic       busy;
  logic       target;
  logic [7:0] cnt;
  // mechanism travel takes delay_in + 1 cycles; a stuck breaker ignores trips
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      closed <= 1'b1;
      busy   <= 1'b0;
      target <= 1'b1;
      cnt    <= 8'h00;
    end else if (!busy && trip_in && closed && !stuck_in) begin
      busy   <= 1'b1;
      target <= 1'b0;
      cnt    <= delay_in;
    end else if (!busy && close_in && !closed) begin
      busy   <= 1'b1;
      target <= 1'b1;
      cnt    <= delay_in;
    end else if (busy && cnt == 8'h00) begin
      busy   <= 1'b0;
      closed <= target;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
    end
  end
  // both contacts always driven, one the inverse of the other
  assign closed_out = closed;
  assign open_out   = !closed;
endmodule : breaker_model
`default_nettype wire

// ==== test_breaker_autoreclose_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    fail_count++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); \
  end \
end
module test_breaker_autoreclose_sequencer;
  localparam int DIV = 4;
  localparam int TW = 16;
  localparam int HOLD = 10;
  localparam int RST_T = 100;
  localparam int TO_T = 30;
  localparam logic [1:0] S_EN = ar_pkg::STAT_ENABLED;
  localparam logic [1:0] S_DIS = ar_pkg::STAT_DISABLED;
  localparam logic [1:0] S_PRG = ar_pkg::STAT_PROGRESS;
  localparam logic [1:0] S_LCK = ar_pkg::STAT_LOCKOUT;
  logic mclk_in, rst_in, ar_enable_in, contact_fitted_in, manual_close_in;
  logic cur_sup_enable_in, cur_lockout_enable_in, oc_trip_in, oc_active_in;
  logic ext_initiate_in, block_in, cancel_in, breaker_fail_in, close_block_in;
  logic breaker_closed_contact_in, breaker_open_contact_in, sync_reset_in;
  logic panel_reset_in, reset_input_in, comms_reset_in, close_relay_out;
  logic [2:0] shot_limit_in, settings_bank_out, shot_count_out;
  logic [4*TW-1:0] dead_time_in;
  logic [TW-1:0] sequence_reset_time_in, manual_close_hold_time_in;
  logic [TW-1:0] shot_timeout_in;
  logic [35:0] cur_sup_level_in;
  logic [11:0] cur_lockout_level_in, fault_current_in;
  logic [1:0] status_out;
  logic brk_trip, stuck;
  logic [7:0] brk_delay;
  int fail_count = 0;
  int checked = 0;
  int closes = 0;
  breaker_autoreclose_sequencer #(.TICK_DIV(DIV)) u_dut (.*);
  breaker_model u_brk (.mclk_in(mclk_in), .rst_in(rst_in),
    .trip_in(brk_trip), .close_in(close_relay_out | manual_close_in),
    .stuck_in(stuck), .delay_in(brk_delay),
    .closed_out(breaker_closed_contact_in),
    .open_out(breaker_open_contact_in));
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  // counted mid-cycle, where the one-cycle close pulse has settled
  always @(negedge mclk_in) if (close_relay_out === 1'b1) closes++;
  task automatic finish_test;
    if (fail_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic wait_for(input logic [2:0] v, input bit st, input int lim,
                          output int n);
    n = 0;
    while ((st ? {1'b0, status_out} : shot_count_out) !== v && n < lim) begin
      @(negedge mclk_in);
      n++;
    end
  endtask : wait_for
  // trip or external initiate, breaker told to open
  task automatic fault(input bit ext);
    if (ext) ext_initiate_in = 1'b1;
    else oc_trip_in = 1'b1;
    brk_trip = 1'b1;
    repeat (12) @(negedge mclk_in);
    {oc_trip_in, ext_initiate_in, brk_trip} = 3'h0;
  endtask : fault
  task automatic man_close;
    manual_close_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    manual_close_in = 1'b0;
  endtask : man_close
  task automatic shot(input logic [2:0] k, output int n);
    int c0;
    c0 = closes;
    fault(1'b0);
    `CHK(status_out, S_PRG)
    n = 0;
    while (closes == c0 && n < 300) begin
      @(negedge mclk_in);
      n++;
    end
    repeat (2) @(negedge mclk_in);
    `CHK(closes, c0 + 1)
    `CHK(shot_count_out, k)
    `CHK(settings_bank_out, k)
    repeat (6) @(negedge mclk_in);
  endtask : shot
  // lockout cleared by each reset source
  task automatic clear(input int i);
    int n;
    panel_reset_in = (i == 0);
    reset_input_in = (i == 1);
    comms_reset_in = (i == 2);
    sync_reset_in = (i == 3);
    repeat (2) @(negedge mclk_in);
    {panel_reset_in, reset_input_in, comms_reset_in, sync_reset_in} = 4'h0;
    wait_for(S_EN, 1, 20, n);
    `CHK(status_out, S_EN)
    `CHK(shot_count_out, 3'h0)
  endtask : clear
  task automatic t_enable;
    for (int i = 0; i < 5; i++) begin
      block_in = (i == 0);
      cancel_in = (i == 1);
      contact_fitted_in = (i != 2);
      ar_enable_in = (i != 3);
      repeat (10) @(negedge mclk_in);
      `CHK(status_out, (i == 4) ? S_EN : S_DIS)
    end
  endtask : t_enable
  // abandon when breaker stuck or close blocked
  task automatic t_timeout;
    int n;
    int c0;
    for (int k = 0; k < 2; k++) begin
      stuck = (k == 0);
      close_block_in = (k == 1);
      c0 = closes;
      fault(1'b0);
      wait_for(S_EN, 1, TO_T * DIV + 60, n);
      `CHK(n + 12 >= TO_T * DIV - DIV, 1'b1)
      `CHK(status_out, S_EN)
      `CHK(closes, c0)
    end
    {stuck, close_block_in} = 2'h0;
    man_close();
    repeat (4) @(negedge mclk_in);
    `CHK(status_out, S_DIS)
    repeat (RST_T * DIV) @(negedge mclk_in);
  endtask : t_timeout
  task automatic t_one_shot;
    int n;
    int m;
    brk_delay = 8'h3c;
    shot(3'h1, n);
    `CHK(n + 12 >= 60 + 5 * DIV, 1'b1)
    brk_delay = 8'h02;
    wait_for(3'h0, 0, RST_T * DIV + 40, m);
    `CHK(n + m + 20 >= RST_T * DIV - DIV, 1'b1)
    `CHK(shot_count_out, 3'h0)
    `CHK(settings_bank_out, 3'h0)
    // forget the auto reset, or the next trip counts as pumping
    clear(0);
  endtask : t_one_shot
  task automatic t_shots(input logic [2:0] lim);
    int n;
    int c0;
    shot_limit_in = lim;
    for (int k = 1; k <= lim; k++) shot(3'(k), n);
    c0 = closes;
    fault(1'b0);
    wait_for(S_LCK, 1, 20, n);
    `CHK(status_out, S_LCK)
    `CHK(settings_bank_out, 3'h0)
    repeat (60) @(negedge mclk_in);
    `CHK(closes, c0)
  endtask : t_shots
  // manual close under an active overcurrent, then clean
  task automatic t_manual;
    int n;
    oc_active_in = 1'b1;
    man_close();
    repeat (HOLD * DIV + 30) @(negedge mclk_in);
    `CHK(status_out, S_LCK)
    oc_active_in = 1'b0;
    man_close();
    wait_for(S_EN, 1, HOLD * DIV + 40, n);
    `CHK(status_out, S_EN)
    `CHK(shot_count_out, 3'h0)
  endtask : t_manual
  // high current cuts shots, highest level locks out at once
  task automatic t_cursup;
    int n;
    cur_sup_enable_in = 1'b1;
    fault_current_in = 12'h15e;
    shot(3'h1, n);
    fault(1'b0);
    wait_for(S_LCK, 1, 20, n);
    `CHK(status_out, S_LCK)
    clear(0);
    cur_lockout_enable_in = 1'b1;
    fault_current_in = 12'h1f4;
    fault(1'b0);
    `CHK(status_out, S_LCK)
    clear(2);
    {cur_sup_enable_in, cur_lockout_enable_in} = 2'h0;
  endtask : t_cursup
  // breaker failure from idle and mid-sequence
  task automatic t_resets;
    for (int i = 0; i < 4; i++) begin
      if (i == 1) begin
        fault(1'b1);
        `CHK(status_out, S_PRG)
      end
      breaker_fail_in = 1'b1;
      repeat (8) @(negedge mclk_in);
      `CHK(status_out, S_LCK)
      breaker_fail_in = 1'b0;
      // the synchronised failure input still holds lockout for a while
      repeat (6) @(negedge mclk_in);
      clear(i);
    end
  endtask : t_resets
  initial begin
    repeat (20000) @(posedge mclk_in);
    fail_count++;
    finish_test();
  end
  initial begin
    rst_in = 1'b1;
    {ar_enable_in, contact_fitted_in} = 2'h3;
    {block_in, cancel_in, close_block_in, breaker_fail_in} = 4'h0;
    {oc_trip_in, oc_active_in, ext_initiate_in, manual_close_in} = 4'h0;
    {panel_reset_in, reset_input_in, comms_reset_in, sync_reset_in} = 4'h0;
    {cur_sup_enable_in, cur_lockout_enable_in, brk_trip, stuck} = 4'h0;
    brk_delay = 8'h02;
    shot_limit_in = 3'h4;
    dead_time_in = {4{16'h0006}};
    sequence_reset_time_in = 16'(RST_T);
    manual_close_hold_time_in = 16'(HOLD);
    shot_timeout_in = 16'(TO_T);
    cur_sup_level_in = {12'h12c, 12'h0c8, 12'h064};
    cur_lockout_level_in = 12'h190;
    fault_current_in = 12'h000;
    repeat (8) @(negedge mclk_in);
    `CHK({close_relay_out, settings_bank_out, shot_count_out}, 7'h00)
    `CHK(status_out, S_DIS)
    rst_in = 1'b0;
    repeat (12) @(negedge mclk_in);
    t_enable();
    t_timeout();
    t_one_shot();
    t_shots(3'h4);
    t_manual();
    t_cursup();
    t_resets();
    finish_test();
  end
endmodule : test_breaker_autoreclose_sequencer
`default_nettype wire
